//--- hw/dkirq_pkg.sv
package dkirq_pkg;

    // Disk operation that the sequencer is running
    typedef enum logic [1:0] {
        DKIRQ_OP_NONE,
        DKIRQ_OP_READ,
        DKIRQ_OP_WRITE,
        DKIRQ_OP_CHECK
    } dkirq_op_e;

    // Header operation of the current sector
    typedef enum logic [1:0] {
        DKIRQ_HDR_COMPARE,
        DKIRQ_HDR_READ,
        DKIRQ_HDR_IGNORE,
        DKIRQ_HDR_WRITE
    } dkirq_hdr_e;

    // Who moves the data on a disk read
    typedef enum logic [1:0] {
        DKIRQ_DMA_LOCAL,
        DKIRQ_DMA_DUAL,
        DKIRQ_DMA_EXTERNAL
    } dkirq_dma_e;

    // Error register bits other than the correction-failed bit
    localparam int DKIRQ_ERR_W = 7;
    localparam logic [DKIRQ_ERR_W-1:0] DKIRQ_ERR_RST = 7'h00;

    // Status flag vector layout
    localparam int DKIRQ_FLAG_W = 5;
    localparam int DKIRQ_F_NEXT_CMD = 0;
    localparam int DKIRQ_F_HDR_DONE = 1;
    localparam int DKIRQ_F_OP_DONE = 2;
    localparam int DKIRQ_F_ERROR = 3;
    localparam int DKIRQ_F_CORR_DONE = 4;
    localparam logic [DKIRQ_FLAG_W-1:0] DKIRQ_FLAGS_RST = 5'h00;

    // Reset values of the read-strobe synchroniser and the pin
    localparam logic [1:0] DKIRQ_RD_SYNC_RST = 2'h3;
    localparam logic DKIRQ_INT_N_RST = 1'h1;

endpackage

//--- hw/dkirq_evt_if.sv
`timescale 1ns/1ps
interface dkirq_evt_if;
    import dkirq_pkg::*;

    dkirq_op_e op_kind;
    dkirq_hdr_e hdr_kind;
    dkirq_dma_e dma_mode;
    logic tracking;
    logic remote_en;
    logic last_sector;
    logic data_post_last_out;
    logic data_post_first_in;
    logic local_last_wr;
    logic remote_last_rd;
    logic id_post_first_read;
    logic id_post_first_written;
    logic op_done;
    logic hdr_done;

    modport qual (
        input op_kind,
        input hdr_kind,
        input dma_mode,
        input tracking,
        input remote_en,
        input last_sector,
        input data_post_last_out,
        input data_post_first_in,
        input local_last_wr,
        input remote_last_rd,
        input id_post_first_read,
        input id_post_first_written,
        output op_done,
        output hdr_done
    );

    modport top (
        output op_kind,
        output hdr_kind,
        output dma_mode,
        output tracking,
        output remote_en,
        output last_sector,
        output data_post_last_out,
        output data_post_first_in,
        output local_last_wr,
        output remote_last_rd,
        output id_post_first_read,
        output id_post_first_written,
        input op_done,
        input hdr_done
    );
endinterface

//--- hw/dkirq_qual.sv
`timescale 1ns/1ps
module dkirq_qual (
    dkirq_evt_if.qual evt
);
    import dkirq_pkg::*;

    logic use_remote;
    logic remote_any_op;
    logic read_evt;
    logic kind_evt;
    logic hdr_evt;

    // Tracking, dual-channel or external DMA end on the last read strobe, non-tracking local-only on the last write
    assign use_remote = evt.tracking ||
                        (evt.dma_mode != DKIRQ_DMA_LOCAL);
    assign read_evt = use_remote ? evt.remote_last_rd : evt.local_last_wr;

    // Non-tracking with remote channel: remote completion overrides the disk side
    assign remote_any_op = !evt.tracking && evt.remote_en;

    assign kind_evt = (evt.op_kind == DKIRQ_OP_WRITE) ? evt.data_post_last_out :
                      (evt.op_kind == DKIRQ_OP_CHECK) ? evt.data_post_first_in :
                      (evt.op_kind == DKIRQ_OP_READ) ? read_evt : 1'b0;

    // Intermediate sectors never complete the operation
    assign evt.op_done = evt.last_sector &&
                         (remote_any_op ? evt.remote_last_rd : kind_evt);

    // Header completion fires every sector, at the first ID postamble byte
    assign hdr_evt = (evt.hdr_kind == DKIRQ_HDR_WRITE) ? evt.id_post_first_written :
                     evt.id_post_first_read;
    assign evt.hdr_done = hdr_evt;
endmodule

//--- hw/dkirq_top.sv
`timescale 1ns/1ps
// Functional notes
// - Interrupt driven only while global enable set
// - Four sources: op, header, error, correction
// - Legal disk operation end raises operation complete
// - Tracking read completes on remote transfer end
// - Non-tracking local-only read completes on local transfer end
// - Non-tracking remote channel: complete on remote end
// - Multi-sector: only last sector completes operation
// - Write completes on last postamble byte out
// - Check data completes on first postamble byte
// - Local-only read completes on last write strobe
// - Dual-channel completes on last read strobe
// - External DMA completes on last read strobe
// - Header interrupt only with its enable set
// - Header interrupt once per sector header
// - Next-command flag set with header interrupt
// - Compare/read/ignore header: first ID postamble read
// - Write header: first ID postamble byte written
// - New error bit sets error flag, interrupts
// - Every correction cycle end raises an interrupt
// - Uncorrectable sets correction-failed only, no extra
// - Status read forces interrupt output high
// - Event during status read asserts after read
// - Soft reset or reset pin deasserts interrupt
// - Drive run bit clear keeps interrupt pending
module dkirq_top (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic IRQ_GLOBAL_ENABLE_BIT,
    input wire logic HEADER_DONE_IRQ_ENABLE_BIT,
    input wire logic SOFT_RESET_BIT,
    input wire dkirq_pkg::dkirq_op_e OP_KIND,
    input wire dkirq_pkg::dkirq_hdr_e HDR_KIND,
    input wire dkirq_pkg::dkirq_dma_e DMA_MODE,
    input wire logic TRACKING_MODE,
    input wire logic REMOTE_DMA_ENABLE,
    input wire logic LAST_SECTOR,
    input wire logic DATA_POST_LAST_OUT,
    input wire logic DATA_POST_FIRST_IN,
    input wire logic LOCAL_LAST_WR_STROBE,
    input wire logic REMOTE_LAST_RD_STROBE,
    input wire logic ID_POST_FIRST_READ,
    input wire logic ID_POST_FIRST_WRITTEN,
    input wire logic [dkirq_pkg::DKIRQ_ERR_W-1:0] ERROR_BITS,
    input wire logic CORR_CYCLE_END,
    input wire logic CORR_UNCORRECTABLE,
    input wire logic STATUS_READ_N,
    output logic INT_N,
    output logic NEXT_COMMAND_FLAG,
    output logic HEADER_DONE_FLAG,
    output logic OP_DONE_FLAG,
    output logic ERROR_SEEN_FLAG,
    output logic CORR_DONE_FLAG,
    output logic CORRECTION_FAILED_FLAG
);
    import dkirq_pkg::*;

    dkirq_evt_if evt ();

    logic [1:0] rd_sync;
    logic rd_act;
    logic rd_act_d;
    logic rd_start;
    logic rd_end;
    logic [DKIRQ_ERR_W-1:0] err_prev;
    logic err_new;
    logic hdr_irq;
    logic [DKIRQ_FLAG_W-1:0] set_flags;
    logic any_evt;
    logic [DKIRQ_FLAG_W-1:0] flags;
    logic [DKIRQ_FLAG_W-1:0] snap;
    logic pend;
    logic cf;
    logic int_n;
    logic next_pend;
    logic [DKIRQ_FLAG_W-1:0] next_flags;
    logic [DKIRQ_FLAG_W-1:0] next_snap;
    logic next_cf;
    logic next_int_n;

    assign evt.op_kind = OP_KIND;
    assign evt.hdr_kind = HDR_KIND;
    assign evt.dma_mode = DMA_MODE;
    assign evt.tracking = TRACKING_MODE;
    assign evt.remote_en = REMOTE_DMA_ENABLE;
    assign evt.last_sector = LAST_SECTOR;
    assign evt.data_post_last_out = DATA_POST_LAST_OUT;
    assign evt.data_post_first_in = DATA_POST_FIRST_IN;
    assign evt.local_last_wr = LOCAL_LAST_WR_STROBE;
    assign evt.remote_last_rd = REMOTE_LAST_RD_STROBE;
    assign evt.id_post_first_read = ID_POST_FIRST_READ;
    assign evt.id_post_first_written = ID_POST_FIRST_WRITTEN;

    dkirq_qual u_qual (
        .evt(evt.qual)
    );

    // Status read strobe passes through a two-flop synchroniser before use
    assign rd_act = !rd_sync[1];
    assign rd_start = rd_act && !rd_act_d;
    assign rd_end = !rd_act && rd_act_d;

    // Only a bit that newly rises interrupts; a standing error does not repeat
    assign err_new = |(ERROR_BITS & ~err_prev);
    assign hdr_irq = evt.hdr_done && HEADER_DONE_IRQ_ENABLE_BIT;

    // Uncorrectable adds nothing here: the cycle end is the single interrupt
    always_comb begin
        set_flags = DKIRQ_FLAGS_RST;
        set_flags[DKIRQ_F_NEXT_CMD] = evt.op_done || hdr_irq;
        set_flags[DKIRQ_F_HDR_DONE] = hdr_irq;
        set_flags[DKIRQ_F_OP_DONE] = evt.op_done;
        set_flags[DKIRQ_F_ERROR] = err_new;
        set_flags[DKIRQ_F_CORR_DONE] = CORR_CYCLE_END;
    end
    assign any_evt = |set_flags;

    // Pending is dropped when a read begins; events inside the read set it again
    assign next_pend = SOFT_RESET_BIT ? 1'b0 :
                       any_evt ? 1'b1 :
                       rd_start ? 1'b0 : pend;

    // Flags seen by the read are cleared at its end; later events survive
    assign next_snap = rd_start ? flags : (snap & ~set_flags);
    assign next_flags = SOFT_RESET_BIT ? DKIRQ_FLAGS_RST :
                        ((rd_end ? (flags & ~snap) : flags) | set_flags);
    assign next_cf = SOFT_RESET_BIT ? 1'b0 :
                     CORR_CYCLE_END ? CORR_UNCORRECTABLE : cf;

    // The run bit is not an input here, so it can never clear a pending interrupt
    assign next_int_n = SOFT_RESET_BIT ? DKIRQ_INT_N_RST :
                        !(IRQ_GLOBAL_ENABLE_BIT && next_pend && !rd_act);

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rd_sync <= DKIRQ_RD_SYNC_RST;
            rd_act_d <= 1'b0;
        end else if (CE) begin
            rd_sync <= {rd_sync[0], STATUS_READ_N};
            rd_act_d <= rd_act;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            err_prev <= DKIRQ_ERR_RST;
            flags <= DKIRQ_FLAGS_RST;
            snap <= DKIRQ_FLAGS_RST;
            pend <= 1'b0;
            cf <= 1'b0;
        end else if (CE) begin
            err_prev <= ERROR_BITS;
            flags <= next_flags;
            snap <= next_snap;
            pend <= next_pend;
            cf <= next_cf;
        end
    end

    // Registered pin keeps decode glitches away from the processor
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            int_n <= DKIRQ_INT_N_RST;
        end else if (CE) begin
            int_n <= next_int_n;
        end
    end

    assign INT_N = int_n;
    assign NEXT_COMMAND_FLAG = flags[DKIRQ_F_NEXT_CMD];
    assign HEADER_DONE_FLAG = flags[DKIRQ_F_HDR_DONE];
    assign OP_DONE_FLAG = flags[DKIRQ_F_OP_DONE];
    assign ERROR_SEEN_FLAG = flags[DKIRQ_F_ERROR];
    assign CORR_DONE_FLAG = flags[DKIRQ_F_CORR_DONE];
    assign CORRECTION_FAILED_FLAG = cf;
endmodule

//--- tb/dkirq_sva.sv
`timescale 1ns/1ps
module dkirq_sva import dkirq_pkg::*; (
    input logic CLK,
    input logic RST_N,
    input logic CE,
    input logic IRQ_GLOBAL_ENABLE_BIT,
    input logic HEADER_DONE_IRQ_ENABLE_BIT,
    input logic SOFT_RESET_BIT,
    input dkirq_pkg::dkirq_op_e OP_KIND,
    input dkirq_pkg::dkirq_hdr_e HDR_KIND,
    input dkirq_pkg::dkirq_dma_e DMA_MODE,
    input logic TRACKING_MODE,
    input logic REMOTE_DMA_ENABLE,
    input logic LAST_SECTOR,
    input logic DATA_POST_LAST_OUT,
    input logic DATA_POST_FIRST_IN,
    input logic LOCAL_LAST_WR_STROBE,
    input logic REMOTE_LAST_RD_STROBE,
    input logic ID_POST_FIRST_READ,
    input logic ID_POST_FIRST_WRITTEN,
    input logic [dkirq_pkg::DKIRQ_ERR_W-1:0] ERROR_BITS,
    input logic CORR_CYCLE_END,
    input logic CORR_UNCORRECTABLE,
    input logic STATUS_READ_N,
    input logic INT_N,
    input logic NEXT_COMMAND_FLAG,
    input logic HEADER_DONE_FLAG,
    input logic OP_DONE_FLAG,
    input logic ERROR_SEEN_FLAG,
    input logic CORR_DONE_FLAG,
    input logic CORRECTION_FAILED_FLAG
);
    default clocking cb @(posedge CLK); endclocking
    // A frozen cycle updates nothing, so no check may count it
    default disable iff (!RST_N || !CE);
    wire live = !SOFT_RESET_BIT;
    wire rem_path = !TRACKING_MODE && REMOTE_DMA_ENABLE;
    wire rd_src = (TRACKING_MODE || DMA_MODE != DKIRQ_DMA_LOCAL) ? REMOTE_LAST_RD_STROBE
        : LOCAL_LAST_WR_STROBE;
    wire op_src = rem_path ? REMOTE_LAST_RD_STROBE : OP_KIND == DKIRQ_OP_WRITE ? DATA_POST_LAST_OUT
        : OP_KIND == DKIRQ_OP_CHECK ? DATA_POST_FIRST_IN : OP_KIND == DKIRQ_OP_READ && rd_src;
    wire op_ev = live && LAST_SECTOR && op_src;
    wire hdr_ev = live && HEADER_DONE_IRQ_ENABLE_BIT
        && (HDR_KIND == DKIRQ_HDR_WRITE ? ID_POST_FIRST_WRITTEN : ID_POST_FIRST_READ);
    wire any_ev = op_ev || hdr_ev || live && CORR_CYCLE_END;
    // Pin to output is two synchroniser flops plus the output flop
    sequence rd_held;
        !STATUS_READ_N [*4];
    endsequence
    // Pin is synchronised, so an idle read needs three quiet samples
    sequence rd_idle;
        STATUS_READ_N && $past(STATUS_READ_N) && $past(STATUS_READ_N, 2);
    endsequence
    chk_gate_off: assert property (!IRQ_GLOBAL_ENABLE_BIT
        && !$past(IRQ_GLOBAL_ENABLE_BIT) |-> INT_N)
        else $error("interrupt low while masked");
    chk_op_flag: assert property (op_ev
        |=> OP_DONE_FLAG && NEXT_COMMAND_FLAG)
        else $error("operation complete flags missing");
    chk_op_cause: assert property ($rose(OP_DONE_FLAG) |-> $past(op_ev))
        else $error("operation complete without its event");
    chk_hdr_flag: assert property (hdr_ev |=> HEADER_DONE_FLAG && NEXT_COMMAND_FLAG)
        else $error("header complete flags missing");
    chk_err_flag: assert property (live
        && |(ERROR_BITS & ~$past(ERROR_BITS)) |=> ERROR_SEEN_FLAG)
        else $error("error flag missing");
    chk_corr_flag: assert property (live && CORR_CYCLE_END |=> CORR_DONE_FLAG
        && CORRECTION_FAILED_FLAG == $past(CORR_UNCORRECTABLE)) else $error("correction flags wrong");
    chk_irq_low: assert property ((any_ev && IRQ_GLOBAL_ENABLE_BIT)
        ##0 rd_idle |=> !INT_N)
        else $error("interrupt not raised");
    chk_read_high: assert property (rd_held |-> INT_N)
        else $error("interrupt low during status read");
    chk_soft_clear: assert property (SOFT_RESET_BIT |=> INT_N && !OP_DONE_FLAG
        && !CORR_DONE_FLAG && !CORRECTION_FAILED_FLAG) else $error("soft reset did not clear");
endmodule
bind dkirq_top dkirq_sva u_sva (.*);

//--- tb/dkirq_host.sv
`timescale 1ns/1ps
module dkirq_host (
    input wire logic CLK,
    output logic STATUS_READ_N
);
    initial STATUS_READ_N = 1'b1;
    task automatic status_read(input int n);
        @(posedge CLK);
        #1 STATUS_READ_N = 1'b0;
        repeat (n) @(posedge CLK);
        #1 STATUS_READ_N = 1'b1;
    endtask
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import dkirq_pkg::*;
    logic clk = 0, rst_n = 0, en = 1, hen = 1, srst = 0, trk = 0, rem = 0, last = 0, unc = 0;
    dkirq_op_e op = DKIRQ_OP_NONE;
    dkirq_hdr_e hk = DKIRQ_HDR_COMPARE;
    dkirq_dma_e dm = DKIRQ_DMA_LOCAL;
    logic [6:0] stb = 7'h00;
    logic [6:0] eb = 7'h00;
    logic ce = 1;
    logic int_n, nc, hd, od, es, cd, cf, sr_n;
    int error_cnt = 0, checks = 0;
    // Row: op, dma, tracking, remote, last sector, expected, strobe
    logic [11:0] tbl [13] = '{12'h831, 12'h801, 12'hc32, 12'hc21, 12'h434, 12'h4a4, 12'h4b8,
        12'h538, 12'h638, 12'h524, 12'h878, 12'h861, 12'h078};
    always #5 clk = ~clk;
    dkirq_top dut (.CLK(clk), .RST_N(rst_n), .CE(ce), .IRQ_GLOBAL_ENABLE_BIT(en),
        .HEADER_DONE_IRQ_ENABLE_BIT(hen), .SOFT_RESET_BIT(srst), .OP_KIND(op), .HDR_KIND(hk),
        .DMA_MODE(dm), .TRACKING_MODE(trk), .REMOTE_DMA_ENABLE(rem), .LAST_SECTOR(last),
        .DATA_POST_LAST_OUT(stb[0]), .DATA_POST_FIRST_IN(stb[1]), .LOCAL_LAST_WR_STROBE(stb[2]),
        .REMOTE_LAST_RD_STROBE(stb[3]), .ID_POST_FIRST_READ(stb[4]),
        .ID_POST_FIRST_WRITTEN(stb[5]), .ERROR_BITS(eb), .CORR_CYCLE_END(stb[6]),
        .CORR_UNCORRECTABLE(unc), .STATUS_READ_N(sr_n), .INT_N(int_n), .NEXT_COMMAND_FLAG(nc),
        .HEADER_DONE_FLAG(hd), .OP_DONE_FLAG(od), .ERROR_SEEN_FLAG(es), .CORR_DONE_FLAG(cd),
        .CORRECTION_FAILED_FLAG(cf));
    dkirq_host host (.CLK(clk), .STATUS_READ_N(sr_n));
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cmp(input string nm, input logic [6:0] exp);
        checks++;
        if ({int_n, nc, hd, od, es, cd, cf} !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, {int_n, nc, hd, od, es, cd, cf});
        end
    endtask
    // Trailing idle edge keeps back-to-back pulses from colliding
    task automatic fire(input logic [6:0] s);
        stb = s;
        tick();
        stb = 7'h00;
        tick();
    endtask
    task automatic rd();
        host.status_read(3);
        tick(4);
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #20000;
        error_cnt++;
        end_sim();
    end
    initial begin
        tick(12);
        rst_n = 1;
        tick();
        for (int i = 0; i < 13; i++) begin
            op = dkirq_op_e'(tbl[i][11:10]);
            dm = dkirq_dma_e'(tbl[i][9:8]);
            {trk, rem, last} = tbl[i][7:5];
            tick();
            fire({3'h0, tbl[i][3:0]});
            cmp("op", {~tbl[i][4], tbl[i][4], 1'b0, tbl[i][4], 3'h0});
            rd();
            cmp("op clear", 7'h40);
        end
        $display("test operation complete done");
        op = DKIRQ_OP_NONE;
        last = 0;
        for (int h = 0; h < 4; h++) begin
            hk = dkirq_hdr_e'(h);
            tick();
            fire(h == 3 ? 7'h10 : 7'h20);
            cmp("hdr other", 7'h40);
            fire(h == 3 ? 7'h20 : 7'h10);
            cmp("hdr", 7'h30);
            rd();
        end
        hen = 0;
        fire(7'h20);
        cmp("hdr off", 7'h40);
        $display("test header complete done");
        eb = 7'h04;
        tick(2);
        cmp("err", 7'h04);
        rd();
        cmp("err standing", 7'h40);
        eb = 7'h06;
        tick(2);
        cmp("err new", 7'h04);
        rd();
        eb = 7'h00;
        unc = 1;
        fire(7'h40);
        cmp("corr fail", 7'h03);
        rd();
        cmp("corr fail kept", 7'h41);
        unc = 0;
        fire(7'h40);
        cmp("corr ok", 7'h02);
        rd();
        $display("test error and correction done");
        fork
            host.status_read(8);
            begin
                tick(4);
                fire(7'h40);
            end
        join
        cmp("held in read", 7'h42);
        tick(3);
        cmp("after read", 7'h02);
        rd();
        en = 0;
        tick();
        fire(7'h40);
        cmp("masked", 7'h42);
        en = 1;
        tick();
        cmp("unmasked", 7'h02);
        ce = 0;
        unc = 1;
        fire(7'h40);
        cmp("frozen", 7'h02);
        ce = 1;
        unc = 0;
        srst = 1;
        tick();
        srst = 0;
        cmp("soft reset", 7'h40);
        fire(7'h40);
        rst_n = 0;
        tick();
        cmp("pin reset", 7'h40);
        rst_n = 1;
        tick();
        $display("test clearing done");
        end_sim();
    end
endmodule
